// [hw/data_map_consts.svh]
`ifndef DATA_MAP_CONSTS_SVH
`define DATA_MAP_CONSTS_SVH
// core register offsets inside every bank
`define OFS_INDIRECT_PORT_0 7'h00
`define OFS_INDIRECT_PORT_1 7'h01
`define OFS_PROGRAM_COUNTER_LOW 7'h02
`define OFS_ALU_RESET_STATUS 7'h03
`define OFS_POINTER0_LOW 7'h04
`define OFS_POINTER0_HIGH 7'h05
`define OFS_POINTER1_LOW 7'h06
`define OFS_POINTER1_HIGH 7'h07
`define OFS_BANK_SELECTOR 7'h08
`define OFS_WORKING_REGISTER 7'h09
`define OFS_PROGRAM_COUNTER_HIGH_LATCH 7'h0A
`define OFS_INTERRUPT_CONTROL 7'h0B
// area boundaries inside a bank
`define OFS_PERIPH_FIRST 7'h0C
`define OFS_PERIPH_LAST 7'h1F
`define OFS_GENERAL_FIRST 7'h20
`define OFS_GENERAL_LAST 7'h6F
`define OFS_COMMON_FIRST 7'h70
`define OFS_COMMON_LAST 7'h7F
// status field positions
`define STAT_CARRY_BIT 0
`define STAT_DIGIT_CARRY_BIT 1
`define STAT_ZERO_BIT 2
`define STAT_POWERDOWN_BIT 3
`define STAT_TIMEOUT_BIT 4
// reset values
`define RST_BYTE 8'h00
`define RST_TIMEOUT_N 1'b1
`define RST_POWERDOWN_N 1'b1
// pointer high byte bit that selects program space
`define PTR_PROGRAM_BIT 7
`endif

// [hw/data_map_pkg.sv]
package data_map_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_DONE = 2'b10
  } access_state_t;
  typedef logic [11:0] data_addr_t;
endpackage

// [hw/data_memory_map.sv]
`timescale 1ns/1ps
`include "data_map_consts.svh"

module data_memory_map
  import data_map_pkg::*;
#(
  parameter int GPR_BANKS = 8,
  parameter int PROG_ADDR_W = 15
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  // cpu file access
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_indirect,
  input wire logic acc_ptr_sel,
  input wire logic [6:0] acc_offset,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_flag_dest,
  output logic acc_done,
  output logic [7:0] acc_rdata,
  output logic acc_stall,
  // alu flag update
  input wire logic alu_valid,
  input wire logic [1:0] alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  output logic [7:0] alu_result,
  // indirect move to working register
  input wire logic indirect_move_instr,
  // reset / power events
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  // program memory read port
  output logic prog_rd,
  output logic [PROG_ADDR_W-1:0] prog_addr,
  input wire logic [13:0] prog_word,
  input wire logic prog_valid,
  // peripheral area port
  output logic periph_sel,
  output logic periph_we,
  output logic [11:0] periph_addr,
  output logic [7:0] periph_wdata,
  input wire logic [7:0] periph_rdata,
  // core register views
  output logic [7:0] status_out,
  output logic [7:0] working_out,
  output logic [4:0] bank_out
);

  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_ADD = 2'h1;
  localparam logic [1:0] OP_SUB = 2'h2;
  localparam logic [1:0] OP_LOGIC = 2'h3;

  // core registers
  logic [7:0] program_counter_low_r;
  logic [7:0] pointer0_low_r, pointer0_high_r, pointer1_low_r, pointer1_high_r;
  logic [4:0] bank_selector_r;
  logic [7:0] working_register_r;
  logic [7:0] program_counter_high_latch_r;
  logic [7:0] interrupt_control_r;
  logic zero_r, digit_carry_r, carry_r, timeout_flag_n_r, powerdown_flag_n_r;
  logic [7:0] gpr_mem [GPR_BANKS*80];
  logic [7:0] common_mem [16];
  access_state_t state_r, state_nxt;
  logic [7:0] acc_rdata_nxt;

  // full data address: bank above offset
  function automatic data_addr_t make_addr(input logic [4:0] bank, input logic [6:0] ofs);
    make_addr = {bank, ofs};
  endfunction

  // pointer values as 16-bit words
  logic [15:0] ptr_sel_word;
  assign ptr_sel_word = acc_ptr_sel ? {pointer1_high_r, pointer1_low_r} : {pointer0_high_r, pointer0_low_r};

  // which port is touched; port 1 follows pointer 1
  logic is_port;
  logic [15:0] port_ptr;
  assign is_port = !acc_indirect && (acc_offset == `OFS_INDIRECT_PORT_0 || acc_offset == `OFS_INDIRECT_PORT_1);
  assign port_ptr = (acc_offset == `OFS_INDIRECT_PORT_1) ? {pointer1_high_r, pointer1_low_r}
                                                        : {pointer0_high_r, pointer0_low_r};

  // effective target: direct uses bank selector, indirect uses pointer
  logic [15:0] eff_ptr;
  logic to_prog;
  data_addr_t eff_addr;
  always_comb begin
    eff_ptr = acc_indirect ? ptr_sel_word : port_ptr;
    to_prog = (acc_indirect || is_port) && eff_ptr[`PTR_PROGRAM_BIT + 8];
    if (acc_indirect || is_port) begin
      eff_addr = eff_ptr[11:0];
    end else begin
      eff_addr = make_addr(bank_selector_r, acc_offset);
    end
  end

  // decode of the seven-bit offset; the general area exists only in banks below GPR_BANKS
  logic [4:0] eff_bank;
  logic [6:0] eff_ofs;
  logic in_core, in_periph, in_gpr, in_common;
  int gpr_index;
  assign eff_bank = eff_addr[11:7];
  assign eff_ofs = eff_addr[6:0];
  assign in_core = eff_ofs < `OFS_PERIPH_FIRST;
  assign in_periph = eff_ofs >= `OFS_PERIPH_FIRST && eff_ofs <= `OFS_PERIPH_LAST;
  assign in_gpr = eff_ofs >= `OFS_GENERAL_FIRST && eff_ofs <= `OFS_GENERAL_LAST
                  && int'(eff_bank) < GPR_BANKS;
  assign in_common = eff_ofs >= `OFS_COMMON_FIRST;
  assign gpr_index = int'(eff_bank) * 80 + int'(eff_ofs - `OFS_GENERAL_FIRST);

  // status byte with unimplemented top bits
  logic [7:0] status_view;
  assign status_view = {3'b000, timeout_flag_n_r, powerdown_flag_n_r, zero_r, digit_carry_r, carry_r};

  // alu arithmetic; subtraction adds the two's complement
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] b_eff;
  logic carry_in;
  always_comb begin
    b_eff = (alu_op == OP_SUB) ? ~alu_b : alu_b;
    carry_in = (alu_op == OP_SUB);
    sum9 = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, carry_in};
    sum5 = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
  end

  logic [7:0] alu_res_comb;
  assign alu_res_comb = (alu_op == OP_LOGIC) ? alu_b : sum9[7:0];

  // core register read mux
  function automatic logic [7:0] core_read(input logic [6:0] ofs, input logic [7:0] st);
    case (ofs)
      `OFS_PROGRAM_COUNTER_LOW: core_read = program_counter_low_r;
      `OFS_ALU_RESET_STATUS: core_read = st;
      `OFS_POINTER0_LOW: core_read = pointer0_low_r;
      `OFS_POINTER0_HIGH: core_read = pointer0_high_r;
      `OFS_POINTER1_LOW: core_read = pointer1_low_r;
      `OFS_POINTER1_HIGH: core_read = pointer1_high_r;
      `OFS_BANK_SELECTOR: core_read = {3'b000, bank_selector_r};
      `OFS_WORKING_REGISTER: core_read = working_register_r;
      `OFS_PROGRAM_COUNTER_HIGH_LATCH: core_read = program_counter_high_latch_r;
      `OFS_INTERRUPT_CONTROL: core_read = interrupt_control_r;
      default: core_read = 8'h00; // ports read through a port themselves give zero
    endcase
  endfunction

  // data read value for a non-program target
  always_comb begin
    acc_rdata_nxt = 8'h00;
    if (in_core) begin
      acc_rdata_nxt = core_read(eff_ofs, status_view);
    end else if (in_periph) begin
      acc_rdata_nxt = periph_rdata;
    end else if (in_gpr) begin
      acc_rdata_nxt = gpr_mem[gpr_index];
    end else if (in_common) begin
      acc_rdata_nxt = common_mem[eff_ofs[3:0]];
    end
  end

  logic wr_now;
  assign wr_now = acc_valid && acc_write && state_r == ST_IDLE && !to_prog;

  // peripheral reads wait one cycle so the data is taken while periph_sel stands
  logic periph_rd_req, periph_wait_r;
  assign periph_rd_req = acc_valid && !acc_write && state_r == ST_IDLE && !to_prog && in_periph;

  // access sequencer: program memory fetch waits in ST_FETCH until prog_valid
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (acc_valid && to_prog) begin
          state_nxt = ST_FETCH;
        end else if (periph_rd_req) begin
          state_nxt = ST_DONE;
        end
      end
      ST_FETCH: begin
        if (prog_valid) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // answer, stall and program read port
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_done <= 1'b0;
      acc_rdata <= `RST_BYTE;
      acc_stall <= 1'b0;
      prog_rd <= 1'b0;
      prog_addr <= '0;
      periph_wait_r <= 1'b0;
    end else begin
      acc_done <= 1'b0;
      prog_rd <= 1'b0;
      periph_wait_r <= periph_rd_req;
      case (state_r)
        ST_IDLE: begin
          if (acc_valid && to_prog) begin
            acc_stall <= 1'b1;
            prog_rd <= 1'b1;
            prog_addr <= eff_ptr[PROG_ADDR_W-1:0];
          end else if (periph_rd_req) begin
            acc_stall <= 1'b1; // requests refused until the peripheral answers
          end else if (acc_valid) begin
            acc_done <= 1'b1;
            acc_rdata <= acc_write ? 8'h00 : acc_rdata_nxt;
          end
        end
        ST_FETCH: begin
          if (prog_valid) begin
            acc_rdata <= prog_word[7:0];
            acc_done <= 1'b1;
            acc_stall <= 1'b0;
          end
        end
        ST_DONE: begin
          acc_stall <= 1'b0;
          if (periph_wait_r) begin
            acc_done <= 1'b1;
            acc_rdata <= periph_rdata;
          end
        end
        default: acc_stall <= 1'b0;
      endcase
    end
  end

  // peripheral area is decoded here, storage lives with the peripherals
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      periph_sel <= 1'b0;
      periph_we <= 1'b0;
      periph_addr <= 12'h000;
      periph_wdata <= `RST_BYTE;
    end else begin
      periph_sel <= acc_valid && state_r == ST_IDLE && !to_prog && in_periph;
      periph_we <= wr_now && in_periph;
      periph_addr <= eff_addr;
      periph_wdata <= acc_wdata;
    end
  end

  // general and common RAM; no reset, contents are undefined at power-up
  always_ff @(posedge core_clk) begin
    if (wr_now && in_gpr) begin
      gpr_mem[gpr_index] <= acc_wdata;
    end
    if (wr_now && in_common) begin
      common_mem[eff_ofs[3:0]] <= acc_wdata;
    end
  end

  // plain core registers written by offset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      program_counter_low_r <= `RST_BYTE;
      pointer0_low_r <= `RST_BYTE;
      pointer0_high_r <= `RST_BYTE;
      pointer1_low_r <= `RST_BYTE;
      pointer1_high_r <= `RST_BYTE;
      bank_selector_r <= 5'h00;
      program_counter_high_latch_r <= `RST_BYTE;
      interrupt_control_r <= `RST_BYTE;
    end else if (wr_now && in_core) begin
      case (eff_ofs)
        `OFS_PROGRAM_COUNTER_LOW: program_counter_low_r <= acc_wdata;
        `OFS_POINTER0_LOW: pointer0_low_r <= acc_wdata;
        `OFS_POINTER0_HIGH: pointer0_high_r <= acc_wdata;
        `OFS_POINTER1_LOW: pointer1_low_r <= acc_wdata;
        `OFS_POINTER1_HIGH: pointer1_high_r <= acc_wdata;
        `OFS_BANK_SELECTOR: bank_selector_r <= acc_wdata[4:0];
        `OFS_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_r <= acc_wdata;
        `OFS_INTERRUPT_CONTROL: interrupt_control_r <= acc_wdata;
        default: ;
      endcase
    end
  end

  // working register: file write or program byte from indirect move
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      working_register_r <= `RST_BYTE;
    end else if (state_r == ST_FETCH && prog_valid && indirect_move_instr) begin
      working_register_r <= prog_word[7:0];
    end else if (wr_now && in_core && eff_ofs == `OFS_WORKING_REGISTER) begin
      working_register_r <= acc_wdata;
    end
  end

  logic status_wr;
  assign status_wr = wr_now && in_core && eff_ofs == `OFS_ALU_RESET_STATUS;

  // arithmetic flags; alu result beats a register write when flagged
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      zero_r <= 1'b0;
      digit_carry_r <= 1'b0;
      carry_r <= 1'b0;
      alu_result <= `RST_BYTE;
    end else begin
      if (alu_valid && alu_op != OP_NONE) begin
        alu_result <= alu_res_comb;
        zero_r <= (alu_res_comb == 8'h00);
        if (alu_op != OP_LOGIC) begin
          digit_carry_r <= sum5[4];
          carry_r <= sum9[8];
        end
      end
      if (status_wr && !acc_flag_dest && !(alu_valid && alu_op != OP_NONE)) begin
        zero_r <= acc_wdata[`STAT_ZERO_BIT];
        digit_carry_r <= acc_wdata[`STAT_DIGIT_CARRY_BIT];
        carry_r <= acc_wdata[`STAT_CARRY_BIT];
      end
    end
  end

  // reset-status flags move only on events, never on software writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timeout_flag_n_r <= `RST_TIMEOUT_N;
      powerdown_flag_n_r <= `RST_POWERDOWN_N;
    end else begin
      if (watchdog_timeout) begin
        timeout_flag_n_r <= 1'b0;
      end else if (watchdog_clear_instr || sleep_instr) begin
        timeout_flag_n_r <= 1'b1;
      end
      if (sleep_instr) begin
        powerdown_flag_n_r <= 1'b0;
      end else if (watchdog_clear_instr) begin
        powerdown_flag_n_r <= 1'b1;
      end
    end
  end

  // registered views of core state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_out <= {3'b000, `RST_TIMEOUT_N, `RST_POWERDOWN_N, 3'b000};
      working_out <= `RST_BYTE;
      bank_out <= 5'h00;
    end else begin
      status_out <= status_view;
      working_out <= working_register_r;
      bank_out <= bank_selector_r;
    end
  end

endmodule

// [verif/map_checker.sv]
`timescale 1ns/1ps
module map_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_indirect,
  input wire logic [6:0] acc_offset,
  input wire logic acc_done,
  input wire logic acc_stall,
  input wire logic alu_valid,
  input wire logic [1:0] alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] alu_result,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  input wire logic prog_rd,
  input wire logic prog_valid,
  input wire logic [7:0] status_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] add_cy_r;
  // add carries worked out apart from the alu, {c, dc}
  always_ff @(posedge core_clk) begin
    add_cy_r <= {({1'b0, alu_a} + {1'b0, alu_b}) > 9'h0FF, (alu_a[3:0] + alu_b[3:0]) > 5'h0F};
  end
  a_status_top_zero: assert property (status_out[7:5] == 3'b000)
    else $error("status top bits set");
  a_direct_one_cycle: assert property (acc_valid && !acc_stall && !acc_indirect && acc_offset > 7'h01
    && (acc_write || acc_offset < 7'h0C || acc_offset > 7'h1F)
    |=> acc_done && !acc_stall) else $error("direct access not done in one cycle");
  a_periph_read_wait: assert property (acc_valid && !acc_stall && !acc_indirect && !acc_write
    && acc_offset >= 7'h0C && acc_offset <= 7'h1F
    |=> acc_stall && !acc_done ##1 acc_done && !acc_stall) else $error("peripheral read not answered");
  a_fetch_stalls: assert property (prog_rd |-> acc_stall && !acc_done)
    else $error("fetch without stall");
  a_fetch_done: assert property (acc_stall && prog_valid |=> acc_done && !acc_stall)
    else $error("fetch answer not finished");
  a_sleep_clears_pd: assert property (sleep_instr |=> ##1 !status_out[3])
    else $error("sleep left powerdown flag set");
  a_timeout_clears_to: assert property (watchdog_timeout |=> ##1 !status_out[4])
    else $error("timeout left flag set");
  a_clear_sets_both: assert property (watchdog_clear_instr && !sleep_instr && !watchdog_timeout
    |=> ##1 status_out[4:3] == 2'b11) else $error("watchdog clear missed flags");
  a_flags_hold: assert property (!(watchdog_clear_instr || sleep_instr || watchdog_timeout)
    |=> ##1 $stable(status_out[4:3])) else $error("reset flags moved");
  a_add_carries: assert property (alu_valid && alu_op == 2'd1
    |=> ##1 status_out[1:0] == {$past(add_cy_r[0]), $past(add_cy_r[1])}) else $error("add carries wrong");
  a_logic_zero: assert property (alu_valid && alu_op == 2'd3
    |=> alu_result == $past(alu_b) ##1 status_out[2] == ($past(alu_result) == 8'h00)) else $error("zero flag wrong");
endmodule
bind data_memory_map map_checker chk_i (.*);

// [verif/prog_model.sv]
`timescale 1ns/1ps
module prog_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic prog_rd,
  input wire logic [14:0] prog_addr,
  output logic [13:0] prog_word,
  output logic prog_valid,
  input wire logic periph_sel,
  input wire logic [11:0] periph_addr,
  output logic [7:0] periph_rdata
);
  logic [14:0] addr_r;
  logic [2:0] cnt_r;
  logic [13:0] word;
  // upper bits set so a full-word load would show
  assign word = {6'h2A, addr_r[7:0] ^ 8'h5A};
  // released buses show the inverse, never a stale hold
  assign prog_word = prog_valid ? word : ~word;
  assign periph_rdata = periph_sel ? periph_addr[7:0] ^ 8'hC3 : ~periph_addr[7:0];
  initial begin
    cnt_r = 3'h0;
    addr_r = 15'h0000;
    prog_valid = 1'b0;
  end
  // fetch answered after one or four cycles
  always @(posedge core_clk) begin
    if (prog_rd) begin
      addr_r <= prog_addr;
      cnt_r <= slow ? 3'h4 : 3'h1;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
    prog_valid <= (cnt_r == 3'h1) && !prog_rd;
  end
endmodule

// [verif/test_data_memory_map.sv]
`timescale 1ns/1ps
module test_data_memory_map;
  logic core_clk, sys_rst, acc_valid, acc_write, acc_indirect, acc_ptr_sel, acc_flag_dest;
  logic acc_done, acc_stall, alu_valid, indirect_move_instr, slow, prog_rd, prog_valid;
  logic watchdog_clear_instr, sleep_instr, watchdog_timeout, periph_sel, periph_we;
  logic [6:0] acc_offset;
  logic [7:0] acc_wdata, acc_rdata, alu_a, alu_b, alu_result, periph_wdata, periph_rdata;
  logic [7:0] status_out, working_out;
  logic [1:0] alu_op;
  logic [4:0] bank_out;
  logic [14:0] prog_addr, seen_prog;
  logic [13:0] prog_word;
  logic [11:0] periph_addr, seen_pa;
  logic [7:0] seen_pw;
  int n_fail = 0, n_checks = 0, last_wait = 0, cyc = 0;
  data_memory_map dut (.*);
  prog_model pm (.*);
  initial core_clk = 0;
  always #2.5 core_clk = ~core_clk;
  // address capture and hang guard
  always @(posedge core_clk) begin
    if (prog_rd) seen_prog <= prog_addr;
    if (periph_sel) seen_pa <= periph_addr;
    if (periph_we) seen_pw <= periph_wdata;
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one request pulse, then wait for done
  task automatic acc(input logic w, ind, ps, input logic [6:0] o, input logic [7:0] d);
    @(negedge core_clk);
    {acc_valid, acc_write, acc_indirect, acc_ptr_sel, acc_offset, acc_wdata} = {1'b1, w, ind, ps, o, d};
    @(negedge core_clk);
    acc_valid = 0;
    last_wait = 0;
    while (acc_done !== 1'b1 && last_wait < 20) begin
      @(negedge core_clk);
      last_wait++;
    end
    if (last_wait == 20) chk(0, 1);
  endtask
  task automatic wr(input logic [6:0] o, input logic [7:0] d);
    acc(1, 0, 0, o, d);
  endtask
  task automatic rdc(input logic [6:0] o, input logic [7:0] exp);
    acc(0, 0, 0, o, 8'h00);
    chk(acc_rdata, exp);
  endtask
  task automatic t_core;
    wr(7'h09, 8'h5C);
    wr(7'h08, 8'h03);
    rdc(7'h09, 8'h5C);
    chk(bank_out, 5'h03);
    chk(working_out, 8'h5C);
    rdc(7'h08, 8'h03);
    $display("core done");
  endtask
  task automatic t_ram;
    wr(7'h08, 8'h01);
    wr(7'h20, 8'hA5);
    wr(7'h08, 8'h02);
    wr(7'h20, 8'h3C);
    wr(7'h70, 8'h96);
    wr(7'h08, 8'h01);
    rdc(7'h20, 8'hA5);
    rdc(7'h70, 8'h96);
    wr(7'h08, 8'h0A);
    wr(7'h20, 8'hFF);
    rdc(7'h20, 8'h00);
    wr(7'h08, 8'h1F);
    rdc(7'h70, 8'h96);
    wr(7'h08, 8'h02);
    rdc(7'h20, 8'h3C);
    rdc(7'h0C, 8'hCF);
    chk(seen_pa, 12'h10C);
    wr(7'h15, 8'h6B);
    @(negedge core_clk);
    chk(seen_pw, 8'h6B);
    chk(seen_pa, 12'h115);
    $display("ram done");
  endtask
  task automatic t_status;
    wr(7'h03, 8'hFF);
    rdc(7'h03, 8'h1F);
    acc_flag_dest = 1;
    wr(7'h03, 8'h00);
    acc_flag_dest = 0;
    @(negedge core_clk);
    chk(status_out, 8'h1F);
    wr(7'h03, 8'h00);
    @(negedge core_clk);
    chk(status_out, 8'h18);
    $display("status done");
  endtask
  task automatic t_alu;
    logic [7:0] va [4] = '{8'h0F, 8'hFF, 8'h05, 8'h03};
    logic [7:0] vb [4] = '{8'h01, 8'h01, 8'h05, 8'h05};
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] h;
    // first two add, last two subtract by two's complement
    for (int i = 0; i < 4; i++) begin
      bb = (i < 2) ? vb[i] : ~vb[i];
      s = {1'b0, va[i]} + {1'b0, bb} + 9'(i / 2);
      h = {1'b0, va[i][3:0]} + {1'b0, bb[3:0]} + 5'(i / 2);
      @(negedge core_clk);
      {alu_valid, alu_op, alu_a, alu_b} = {1'b1, (i < 2) ? 2'd1 : 2'd2, va[i], vb[i]};
      @(negedge core_clk);
      alu_valid = 0;
      chk(alu_result, s[7:0]);
      // status view is registered one cycle after the flags
      @(negedge core_clk);
      chk(status_out[2:0], {s[7:0] == 8'h00, h[4], s[8]});
    end
    {alu_valid, alu_op, alu_b} = {1'b1, 2'd3, 8'h00};
    @(negedge core_clk);
    alu_valid = 0;
    @(negedge core_clk);
    chk(status_out[2], 1'b1);
    $display("alu done");
  endtask
  task automatic ev(input logic [2:0] e, input logic [1:0] exp);
    @(negedge core_clk);
    {watchdog_clear_instr, sleep_instr, watchdog_timeout} = e;
    @(negedge core_clk);
    {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'b000;
    @(negedge core_clk);
    chk(status_out[4:3], exp);
  endtask
  task automatic t_prog;
    wr(7'h23, 8'h44);
    wr(7'h06, 8'h23);
    wr(7'h07, 8'h81);
    slow = 1;
    indirect_move_instr = 1;
    acc(0, 1, 1, 7'h00, 8'h00);
    indirect_move_instr = 0;
    chk(acc_rdata, 8'h79);
    chk(seen_prog, 15'h0123);
    chk(last_wait > 2, 1);
    @(negedge core_clk);
    chk(working_out, 8'h79);
    acc(1, 1, 1, 7'h00, 8'hEE);
    rdc(7'h23, 8'h44);
    slow = 0;
    acc(0, 1, 1, 7'h00, 8'h00);
    chk(acc_rdata, 8'h79);
    wr(7'h04, 8'h70);
    wr(7'h05, 8'h01);
    acc(0, 1, 0, 7'h00, 8'h00);
    chk(acc_rdata, 8'h96);
    $display("program read done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {acc_valid, acc_write, acc_indirect, acc_ptr_sel, acc_offset, acc_wdata, acc_flag_dest} = '0;
    {alu_valid, alu_op, alu_a, alu_b, indirect_move_instr, slow} = '0;
    {watchdog_clear_instr, sleep_instr, watchdog_timeout} = 3'b000;
    sys_rst = 1;
    repeat (10) @(negedge core_clk);
    sys_rst = 0;
    chk(status_out, 8'h18);
    t_core;
    t_ram;
    t_status;
    t_alu;
    ev(3'b010, 2'b10);
    ev(3'b011, 2'b00);
    ev(3'b100, 2'b11);
    ev(3'b001, 2'b01);
    ev(3'b110, 2'b10);
    ev(3'b100, 2'b11);
    $display("events done");
    t_prog;
    finish_test;
  end
endmodule
